// *** design/cdb_defines.svh ***
// clock divider bank: register indices, field positions and reset values
// Operation
// - prescaler divides reference by code plus one
// - first post-divider enable bit fifteen
// - first post-divider codes: 1, 2, 4
// - first post-divider resets enabled, divide by four
// - post-dividers follow the bypass/pll selection
// - second post-divider enable bit, resets set
// - second post-divider codes: 1, 2, 4
// - second post-divider resets to divide by four
// - third post-divider enable bit, resets set
// - third post-divider codes: 1, 2, 4
// - third post-divider resets to divide by four
// - oscillator divider fed straight from reference
// - bits fourteen to five read zero
// - path select: zero bypass, one pll
// - prescaler enable bit fifteen, resets set
// - oscillator divider code plus one, starts disabled
`ifndef CDB_DEFINES_SVH
`define CDB_DEFINES_SVH

// register indices; the byte address is four times the index
`define CDB_IDX_PRESCALE 14'h1c8a
`define CDB_IDX_DIV1 14'h1c8c
`define CDB_IDX_DIV2 14'h1c8e
`define CDB_IDX_DIV3 14'h1c90
`define CDB_IDX_OSC 14'h1c92
`define CDB_IDX_CTRL 14'h1c94
`define CDB_IDX_STATUS 14'h1c96

// field positions inside every divider register, and the path bit of the control register
`define CDB_EN_BIT 15
`define CDB_RATIO_MSB 4
`define CDB_PATH_BIT 0

// reset values: enables per divider, bit 0 prescaler .. bit 4 oscillator
`define CDB_RST_EN 5'h0f
`define CDB_RST_RATIO_PRE 5'h00
`define CDB_RST_RATIO_POST 5'h03
`define CDB_RST_RATIO_OSC 5'h00

// axi answers
`define CDB_RESP_OKAY 2'h0
`define CDB_RESP_DECERR 2'h3

`endif

// *** design/cdb_pkg.sv ***
// clock divider bank: shared types
package cdb_pkg;

	// divider output state, one-hot
	typedef enum logic [2:0] {
		CDB_STOPPED = 3'b001,
		CDB_RUNNING = 3'b010,
		CDB_DRAINING = 3'b100
	} cdb_div_state_t;

	// whole state of the bank top
	typedef struct packed {
		logic aw_full;
		logic [13:0] aw_idx;
		logic w_full;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [4:0] en;
		logic [4:0][4:0] ratio;
		logic path_sel;
		logic [1:0] ref_sync;
		logic ref_prev;
		logic [1:0] pll_sync;
		logic pll_prev;
	} cdb_bank_st_t;

endpackage : cdb_pkg

// *** design/cdb_clk_div.sv ***
// clock divider bank: one glitch-free divider driven by source edges
module cdb_clk_div
	import cdb_pkg::*;
#(
	parameter int unsigned RATIO_W = 5
)(
	input wire logic clock,
	input wire logic nrst,
	input wire logic edge_tick,
	input wire logic enable,
	input wire logic [RATIO_W-1:0] ratio,
	output logic clk_out,
	output logic active
);

	typedef struct packed {
		cdb_div_state_t state;
		logic [RATIO_W-1:0] cnt;
		logic [RATIO_W-1:0] lim;
		logic clk;
	} cdb_div_st_t;

	localparam cdb_div_st_t RST = '{state: CDB_STOPPED, default: '0};

	cdb_div_st_t q;
	cdb_div_st_t d;
	logic term;

	// edge_tick marks both source edges, so code+1 edges per half
	// period gives a period of code+1 source cycles
	assign term = edge_tick && (q.cnt == q.lim);
	assign clk_out = q.clk;
	assign active = (q.state != CDB_STOPPED);

	// ratio changes are taken only at a half-period boundary, so a
	// rewrite never shortens the half period under way
	always_comb begin
		d = q;
		if (edge_tick && !term) begin
			d.cnt = RATIO_W'(q.cnt + 1'b1);
		end
		case (q.state)
			CDB_STOPPED: begin
				d.cnt = '0;
				d.clk = 1'b0;
				if (enable) begin
					d.state = CDB_RUNNING;
					d.lim = ratio;
				end
			end
			CDB_RUNNING: begin
				if (term) begin
					d.cnt = '0;
					d.clk = ~q.clk;
					d.lim = ratio;
				end
				// a high half finishes before stopping: no runt pulse
				if (!enable) begin
					if (q.clk) begin
						d.state = CDB_DRAINING;
					end else begin
						d.state = CDB_STOPPED;
						d.clk = 1'b0;
						d.cnt = '0;
					end
				end
			end
			CDB_DRAINING: begin
				if (term) begin
					d.cnt = '0;
					d.clk = 1'b0;
					d.lim = ratio;
					d.state = enable ? CDB_RUNNING : CDB_STOPPED;
				end else if (enable) begin
					d.state = CDB_RUNNING;
				end
			end
			default: begin
				d = RST;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	AST_STOPPED_LOW: assert property (
		@(posedge clock) disable iff (!nrst)
		(q.state == CDB_STOPPED) |-> !clk_out)
		else $error("stopped divider output not low");

	AST_TOGGLE_AT_TERM: assert property (
		@(posedge clock) disable iff (!nrst)
		(q.state == CDB_RUNNING && term && enable)
		|=> (clk_out != $past(clk_out)))
		else $error("divider missed its half-period toggle");

	AST_NO_RUNT: assert property (
		@(posedge clock) disable iff (!nrst)
		(q.state != CDB_STOPPED && !term) |=> $stable(clk_out))
		else $error("divider output moved inside a half period");

endmodule : cdb_clk_div

// *** design/cdb_bank.sv ***
// clock divider bank top: axi4-lite register file and divider array
`include "cdb_defines.svh"
module cdb_bank
	import cdb_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [15:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [15:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic ref_clk_in,
	input wire logic pll_clk_in,
	output logic pll_path_select,
	output logic prescale_clk_out,
	output logic system_clock_one,
	output logic system_clock_two,
	output logic system_clock_three,
	output logic third_output_clock
);

	// index table, element i belongs to divider i
	localparam logic [4:0][13:0] DIV_IDX = {
		`CDB_IDX_OSC,
		`CDB_IDX_DIV3,
		`CDB_IDX_DIV2,
		`CDB_IDX_DIV1,
		`CDB_IDX_PRESCALE
	};

	cdb_bank_st_t q;
	cdb_bank_st_t d;
	logic wr_fire;
	logic ref_tick;
	logic pll_tick;
	logic post_tick;
	logic [4:0] div_clk;
	logic [4:0] div_active;
	logic [4:0] w_ratio;

	// bus handshakes: one write and one read in flight at most
	assign awready = !q.aw_full && !q.bvalid;
	assign wready = !q.w_full && !q.bvalid;
	assign arready = !q.rvalid;
	assign wr_fire = q.aw_full && q.w_full && !q.bvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign w_ratio = q.w_data[`CDB_RATIO_MSB:0];

	// source edges from the second synchroniser stage only; both
	// edges count, so sources must stay below half of clock
	assign ref_tick = q.ref_sync[1] ^ q.ref_prev;
	assign pll_tick = q.pll_sync[1] ^ q.pll_prev;
	assign post_tick = q.path_sel ? pll_tick : ref_tick;
	assign pll_path_select = q.path_sel;

	// clock outputs come straight from divider flip-flops
	assign prescale_clk_out = div_clk[0];
	assign system_clock_one = div_clk[1];
	assign system_clock_two = div_clk[2];
	assign system_clock_three = div_clk[3];
	assign third_output_clock = div_clk[4];

	// next state: synchronisers, bus channels, register writes, reads
	always_comb begin
		logic wr_hit;
		logic rd_hit;
		logic [31:0] rd_word;
		logic [13:0] rd_idx;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		rd_word = '0;
		rd_idx = araddr[15:2];
		d = q;
		d.ref_sync = {q.ref_sync[0], ref_clk_in};
		d.ref_prev = q.ref_sync[1];
		d.pll_sync = {q.pll_sync[0], pll_clk_in};
		d.pll_prev = q.pll_sync[1];

		// address and data are caught independently, in either order
		if (awvalid && awready) begin
			d.aw_full = 1'b1;
			d.aw_idx = awaddr[15:2];
		end
		if (wvalid && wready) begin
			d.w_full = 1'b1;
			d.w_data = wdata[15:0];
			d.w_strb = wstrb[1:0];
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end

		// only bits 15 and 4:0 are stored; others are dropped
		if (wr_fire) begin
			for (int i = 0; i < 5; i++) begin
				if (q.aw_idx == DIV_IDX[i]) begin
					wr_hit = 1'b1;
					if (q.w_strb[0]) begin
						d.ratio[i] = w_ratio;
					end
					if (q.w_strb[1]) begin
						d.en[i] = q.w_data[`CDB_EN_BIT];
					end
				end
			end
			if (q.aw_idx == `CDB_IDX_CTRL) begin
				wr_hit = 1'b1;
				if (q.w_strb[0]) begin
					d.path_sel = q.w_data[`CDB_PATH_BIT];
				end
			end
			// status is read-only; a write there is accepted and dropped
			if (q.aw_idx == `CDB_IDX_STATUS) begin
				wr_hit = 1'b1;
			end
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_hit ? `CDB_RESP_OKAY : `CDB_RESP_DECERR;
		end

		// read word assembly; bits 14:5 stay zero
		for (int i = 0; i < 5; i++) begin
			if (rd_idx == DIV_IDX[i]) begin
				rd_hit = 1'b1;
				rd_word[`CDB_EN_BIT] = q.en[i];
				rd_word[`CDB_RATIO_MSB:0] = q.ratio[i];
			end
		end
		if (rd_idx == `CDB_IDX_CTRL) begin
			rd_hit = 1'b1;
			rd_word[`CDB_PATH_BIT] = q.path_sel;
		end
		if (rd_idx == `CDB_IDX_STATUS) begin
			rd_hit = 1'b1;
			rd_word[4:0] = div_active;
		end
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			d.rvalid = 1'b1;
			d.rdata = rd_word;
			d.rresp = rd_hit ? `CDB_RESP_OKAY : `CDB_RESP_DECERR;
		end
	end

	// state register; every field resets to a constant
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.en <= `CDB_RST_EN;
			q.ratio <= {
				`CDB_RST_RATIO_OSC,
				`CDB_RST_RATIO_POST,
				`CDB_RST_RATIO_POST,
				`CDB_RST_RATIO_POST,
				`CDB_RST_RATIO_PRE
			};
		end else begin
			q <= d;
		end
	end

	// divider array: prescaler and oscillator divider run from the
	// reference, the three post-dividers from the selected path
	for (genvar g = 0; g < 5; g++) begin : g_div
		logic tick;
		if (g == 0 || g == 4) begin : g_ref
			assign tick = ref_tick;
		end else begin : g_post
			assign tick = post_tick;
		end
		// reserved post codes simply divide by code plus one
		cdb_clk_div #(
			.RATIO_W(5)
		) u_div (
			.clock(clock),
			.nrst(nrst),
			.edge_tick(tick),
			.enable(q.en[g]),
			.ratio(q.ratio[g]),
			.clk_out(div_clk[g]),
			.active(div_active[g])
		);
	end

	// read words never carry the unused middle bits
	AST_RESERVED_READ_ZERO: assert property (
		@(posedge clock) disable iff (!nrst)
		q.rvalid |-> (q.rdata[14:5] == 10'h000))
		else $error("reserved bits read nonzero");

	// defaults as seen at the first edge after reset lets go
	AST_RESET_DEFAULTS: assert property (
		@(posedge clock) disable iff (!nrst)
		$rose(nrst) |-> (q.en == 5'h0f && q.ratio[1] == 5'h03
		&& q.ratio[2] == 5'h03 && q.ratio[3] == 5'h03
		&& q.ratio[0] == 5'h00 && q.ratio[4] == 5'h00))
		else $error("divider reset values wrong");

	// written against the raw ticks, so a swapped mux is caught
	AST_PATH_MUX: assert property (
		@(posedge clock) disable iff (!nrst)
		(q.path_sel ? !pll_tick : !ref_tick)
		|=> $stable(system_clock_two))
		else $error("post-divider source does not follow path select");

	// post-dividers move only on an edge of the selected source
	AST_POST_SOURCE: assert property (
		@(posedge clock) disable iff (!nrst)
		!post_tick |=> $stable(system_clock_one))
		else $error("first system clock moved without a source edge");

	AST_POST_THREE_SOURCE: assert property (
		@(posedge clock) disable iff (!nrst)
		(q.path_sel ? !pll_tick : !ref_tick)
		|=> $stable(system_clock_three))
		else $error("third system clock moved without a source edge");

	// oscillator divider and prescaler ignore the pll path entirely
	AST_OSC_FROM_REF: assert property (
		@(posedge clock) disable iff (!nrst)
		!ref_tick |=> $stable(third_output_clock))
		else $error("third output clock moved without a reference edge");

	AST_PRESCALE_FROM_REF: assert property (
		@(posedge clock) disable iff (!nrst)
		!ref_tick |=> $stable(prescale_clk_out))
		else $error("prescaler output moved without a reference edge");

	// register writes land one edge after the commit
	AST_PRESCALE_WRITE: assert property (
		@(posedge clock) disable iff (!nrst)
		(wr_fire && q.aw_idx == `CDB_IDX_PRESCALE && q.w_strb[0])
		|=> (q.ratio[0] == $past(w_ratio)))
		else $error("prescaler ratio write lost");

	AST_ENABLE_WRITE: assert property (
		@(posedge clock) disable iff (!nrst)
		(wr_fire && q.aw_idx == `CDB_IDX_DIV1 && q.w_strb[1])
		|=> (q.en[1] == $past(q.w_data[`CDB_EN_BIT])))
		else $error("first post-divider enable write lost");

	// every divider keeps both fields of a full-width write
	for (genvar g = 0; g < 5; g++) begin : g_chk
		AST_FIELD_WRITE: assert property (
			@(posedge clock) disable iff (!nrst)
			(wr_fire && q.aw_idx == DIV_IDX[g] && q.w_strb == 2'h3)
			|=> (q.en[g] == $past(q.w_data[`CDB_EN_BIT])
			&& q.ratio[g] == $past(w_ratio)))
			else $error("divider field write lost");
	end

	// the path select bit keeps what software wrote
	AST_PATH_WRITE: assert property (
		@(posedge clock) disable iff (!nrst)
		(wr_fire && q.aw_idx == `CDB_IDX_CTRL && q.w_strb[0])
		|=> (q.path_sel == $past(q.w_data[`CDB_PATH_BIT])))
		else $error("path select write lost");

	// the write answer follows the edge that commits the write
	AST_WRITE_ANSWER: assert property (
		@(posedge clock) disable iff (!nrst)
		wr_fire |=> bvalid)
		else $error("write answer missing after commit");

	// answers stand until the master takes them
	AST_BRESP_HOLD: assert property (
		@(posedge clock) disable iff (!nrst)
		(bvalid && !bready) |=> (bvalid && $stable(bresp)))
		else $error("write response dropped before bready");

	AST_RDATA_HOLD: assert property (
		@(posedge clock) disable iff (!nrst)
		(rvalid && !rready)
		|=> (rvalid && $stable(rdata) && $stable(rresp)))
		else $error("read answer dropped before rready");

	// a refused read carries an all-zero word
	AST_UNMAPPED_ZERO: assert property (
		@(posedge clock) disable iff (!nrst)
		(rvalid && rresp == `CDB_RESP_DECERR) |-> (rdata == 32'h0))
		else $error("refused read returned data");

endmodule : cdb_bank

// *** test/cdb_bank_bench.sv ***
// self-checking bench for the clock divider bank
`include "cdb_defines.svh"
module cdb_bank_bench
	import cdb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, pll_path_select;
	logic prescale_clk_out, system_clock_one, system_clock_two;
	logic system_clock_three, third_output_clock;
	logic ref_clk_in = 1'b0;
	logic pll_clk_in = 1'b0;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [4:0] outs;
	logic [13:0] idx [5];
	int miscompares, n_checks;
	int rc = 0;
	int pc = 0;
	assign outs = {third_output_clock, system_clock_three, system_clock_two,
		system_clock_one, prescale_clk_out};
	assign idx = '{`CDB_IDX_PRESCALE, `CDB_IDX_DIV1, `CDB_IDX_DIV2,
		`CDB_IDX_DIV3, `CDB_IDX_OSC};
	cdb_bank cdb_bank_i (.clock(clock), .nrst(nrst), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.ref_clk_in(ref_clk_in), .pll_clk_in(pll_clk_in),
		.pll_path_select(pll_path_select), .prescale_clk_out(prescale_clk_out),
		.system_clock_one(system_clock_one), .system_clock_two(system_clock_two),
		.system_clock_three(system_clock_three),
		.third_output_clock(third_output_clock));
	// 25 mhz system clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// sources locked to clock: ref 10 cycles, pll 12 cycles per period
	always @(posedge clock) begin
		rc <= (rc == 4) ? 0 : rc + 1;
		pc <= (pc == 5) ? 0 : pc + 1;
		if (rc == 4) ref_clk_in <= ~ref_clk_in;
		if (pc == 5) pll_clk_in <= ~pll_clk_in;
	end
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// every wait is bounded; running out ends the run as a mismatch
	task guard(inout int n);
		n++;
		if (n > 3000) begin
			miscompares++;
			$display("[FAIL] wait bound expected 3000 seen %0d", n);
			wrap_up();
		end
	endtask : guard
	task chk_reg(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	task chk_per(string nm, int e, int g);
		n_checks++;
		if (g != e) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_per
	// axi4-lite write; address and data offered together, each held until taken
	task axw(logic [15:0] a, logic [31:0] d, output logic [1:0] r);
		int n;
		logic da, dw, db, ta, tw;
		n = 0; da = 0; dw = 0; db = 0;
		@(posedge clock);
		awaddr <= a; wdata <= d; wstrb <= 4'hf;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!db) begin
			@(negedge clock);
			guard(n);
			ta = !da && awready; tw = !dw && wready;
			db = da && dw && bvalid; r = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (db) bready <= 1'b0;
			da |= ta; dw |= tw;
		end
	endtask : axw
	task axr(logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic da, db, ta;
		n = 0; da = 0; db = 0;
		@(posedge clock);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!db) begin
			@(negedge clock);
			guard(n);
			ta = !da && arready; db = da && rvalid; d = rdata; r = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
			if (db) rready <= 1'b0;
			da |= ta;
		end
	endtask : axr
	task wr(logic [15:0] a, logic [31:0] d, logic [1:0] er);
		logic [1:0] r;
		axw(a, d, r);
		chk_reg("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr
	task rd(string nm, logic [15:0] a, logic [31:0] e, logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk_reg(nm, e, d);
		chk_reg("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd
	// period of one output in clock cycles, between its 2nd and 3rd rise
	task meas(int i, output int p);
		int n, k;
		logic pv;
		n = 0; k = 0; p = 0; pv = outs[i];
		while (k < 3) begin
			@(negedge clock);
			guard(n);
			if (k > 1) p++;
			if (outs[i] && !pv) k++;
			pv = outs[i];
		end
	endtask : meas
	function logic [15:0] ba(logic [13:0] x);
		return {x, 2'b00};
	endfunction : ba
	// main sequence
	initial begin
		logic [31:0] d;
		logic [4:0] r;
		int p, hi;
		logic [4:0] codes [3];
		// only legal post codes are ever written
		codes = '{5'h00, 5'h01, 5'h03};
		nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; awaddr = 16'h0000; araddr = 16'h0000;
		wdata = 32'h0; wstrb = 4'h0;
		miscompares = 0; n_checks = 0;
		void'($urandom(73568));
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		rd("prescale", ba(idx[0]), 32'h8000, 2'h0);
		for (int i = 1; i < 4; i++)
			rd("post", ba(idx[i]), 32'h8003, 2'h0);
		rd("osc", ba(idx[4]), 32'h0000, 2'h0);
		chk_reg("path", 32'h0, {31'h0, pll_path_select});
		meas(1, p);
		chk_per("sys1 reset", 40, p);
		// unmapped place answers decode error
		wr(16'h0100, $urandom, `CDB_RESP_DECERR);
		rd("unmapped", 16'h0100, 32'h0, `CDB_RESP_DECERR);
		// prescaler and oscillator divider, both fed by the reference only
		for (int k = 0; k < 4; k++) begin
			r = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom % 32);
			wr(ba(`CDB_IDX_CTRL), {31'h0, k[0]}, 2'h0);
			foreach (codes[j]) begin
				if (j == 1) continue;
				d = $urandom;
				d[15] = 1'b1;
				d[4:0] = r;
				wr(ba(idx[j == 0 ? 0 : 4]), d, 2'h0);
			end
			d = {16'h0, 1'b1, 10'h0, r};
			rd("pre rb", ba(idx[0]), d, 2'h0);
			rd("osc rb", ba(idx[4]), d, 2'h0);
			meas(0, p);
			chk_per("prescale", (r + 1) * 10, p);
			meas(4, p);
			chk_per("osc", (r + 1) * 10, p);
		end
		// post-dividers in bypass and pll path, every legal code
		for (int s = 0; s < 2; s++) begin
			wr(ba(`CDB_IDX_CTRL), {31'h0, s[0]}, 2'h0);
			chk_reg("path", s, {31'h0, pll_path_select});
			foreach (codes[j])
				for (int i = 1; i < 4; i++) begin
					d = $urandom;
					d[15] = 1'b1;
					d[4:0] = codes[j];
					wr(ba(idx[i]), d, 2'h0);
					meas(i, p);
					hi = (codes[j] + 1) * (s ? 12 : 10);
					chk_per("post", hi, p);
				end
		end
		// each post-divider: off it holds low, then restarts cleanly;
		// the status word shows exactly that one divider stopped
		for (int i = 1; i < 4; i++) begin
			wr(ba(idx[i]), 32'h0001, 2'h0);
			rd("div off", ba(idx[i]), 32'h0001, 2'h0);
			repeat (40) @(negedge clock);
			hi = 0;
			repeat (100) begin
				@(negedge clock);
				hi += outs[i];
			end
			chk_per("off highs", 0, hi);
			d = 32'h1f ^ (32'h1 << i);
			rd("status", ba(`CDB_IDX_STATUS), d, 2'h0);
			wr(ba(idx[i]), 32'h8001, 2'h0);
			meas(i, p);
			chk_per("restart", 24, p);
		end
		wrap_up();
	end
endmodule : cdb_bank_bench
